// file: design/cpl_err_log_pkg.sv
/*
 * Holds the register map, field positions, reset values and completion
 * status codes of the root-port completion error logger.
 * Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
 */
package cpl_err_log_pkg;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] STATUS_COMMAND_OFS = 8'h00;
  localparam logic [7:0] SEC_STATUS_OFS     = 8'h04;
  localparam logic [7:0] HDR_WORD1_OFS      = 8'h08;
  localparam logic [7:0] HDR_WORD2_OFS      = 8'h0c;
  localparam logic [7:0] ACK_TIMER_OFS      = 8'h10;
  localparam logic [7:0] IRQ_STATUS_OFS     = 8'h14;
  localparam logic [7:0] IRQ_MASK_OFS       = 8'h18;

  // ==========================================================================
  // Field positions.
  localparam int MASTER_ABORT_BIT = 29;
  localparam int TARGET_ABORT_BIT = 28;
  localparam int CPL_STATUS_LSB   = 21;
  localparam int CPL_STATUS_MSB   = 23;
  localparam int IRQ_UR_BIT       = 0;
  localparam int IRQ_CA_BIT       = 1;
  localparam int IRQ_HDR_BIT      = 2;

  // ==========================================================================
  // Completion status codes and reset values.
  localparam logic [2:0]  CPL_STATUS_UR   = 3'h1;
  localparam logic [2:0]  CPL_STATUS_CA   = 3'h4;
  localparam logic [31:0] ACK_TIMER_RESET = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage : cpl_err_log_pkg

// file: design/cpl_err_log.sv
/*
 * Root-port completion error logger: abort flags in the status/command and
 * secondary status registers, completion header capture, ack timer config
 * and a read-to-clear interrupt, all behind an AXI4-Lite slave.
 * Assumes completion headers arrive from link logic on the same clock.
 */
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
// Contract
// - Unsupported-request completion sets master-abort flag in both status registers.
// - Completer-abort completion sets target-abort flag in both status registers.
// - Each parsed completion header is stored in the header log registers.
// - Header log word one holds completion status in bits 23:21.
// - Writing one ack timer field leaves the other field unchanged.
`timescale 1ns/10ps
module cpl_err_log
  import cpl_err_log_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Completion header from the link logic.
  input  wire logic        cplValid,
  input  wire logic [31:0] cplHdrWord1,
  input  wire logic [31:0] cplHdrWord2,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response.
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read.
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Interrupt.
  output logic             irq
);

  // ==========================================================================
  // Declarations.
  logic [31:0] statusCommand_reg;
  logic [31:0] secStatus_reg;
  logic [31:0] hdrWord1_reg;
  logic [31:0] hdrWord2_reg;
  logic [31:0] ackTimer_reg;
  logic [2:0]  irqStatus_reg;
  logic [2:0]  irqMask_reg;
  logic        awHeld_reg;
  logic        wHeld_reg;
  logic [7:0]  wrAddr_reg;
  logic [31:0] wrData_reg;
  logic [3:0]  wrStrb_reg;
  logic        gotUr;
  logic        gotCa;
  logic        doWrite;
  logic        doRead;
  logic [31:0] wrMask;
  logic [31:0] rdValue_next;
  logic        rdHit_next;

  // Decode the completion status of the arriving header.
  assign gotUr   = cplValid && (cplHdrWord1[CPL_STATUS_MSB:CPL_STATUS_LSB] == CPL_STATUS_UR);
  assign gotCa   = cplValid && (cplHdrWord1[CPL_STATUS_MSB:CPL_STATUS_LSB] == CPL_STATUS_CA);
  assign doWrite = awHeld_reg && wHeld_reg && !bvalid;
  assign doRead  = arvalid && arready;

  // Byte strobes widened to a bit mask; only enabled lanes are touched.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wrMask[i*8 +: 8] = {8{wrStrb_reg[i]}};
    end
  end

  // ==========================================================================
  // AXI4-Lite write channel: address and data are taken in either order.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
      wrAddr_reg <= 8'h00;
      wrData_reg <= 32'h0000_0000;
      wrStrb_reg <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awHeld_reg <= 1'b1;
        awready    <= 1'b0;
        wrAddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_reg  <= 1'b1;
        wready     <= 1'b0;
        wrData_reg <= wdata;
        wrStrb_reg <= wstrb;
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
        bvalid     <= 1'b1;
        case (wrAddr_reg)
          STATUS_COMMAND_OFS, SEC_STATUS_OFS, ACK_TIMER_OFS, IRQ_MASK_OFS,
          HDR_WORD1_OFS, HDR_WORD2_OFS, IRQ_STATUS_OFS: bresp <= RESP_OKAY;
          default: bresp <= RESP_SLVERR;
        endcase
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Status/command and secondary status: flags set by hardware, cleared by
  // writing one. A completion in the same cycle as the clear wins, so an
  // abort is never lost to a racing software clear.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      statusCommand_reg <= 32'h0000_0000;
      secStatus_reg     <= 32'h0000_0000;
    end else begin
      if (doWrite && wrAddr_reg == STATUS_COMMAND_OFS) begin
        statusCommand_reg[15:0] <= (statusCommand_reg[15:0] & ~wrMask[15:0])
                                 | (wrData_reg[15:0] & wrMask[15:0]);
        statusCommand_reg[31:16] <= statusCommand_reg[31:16]
                                  & ~(wrData_reg[31:16] & wrMask[31:16]);
      end
      if (doWrite && wrAddr_reg == SEC_STATUS_OFS) begin
        secStatus_reg[15:0] <= (secStatus_reg[15:0] & ~wrMask[15:0])
                             | (wrData_reg[15:0] & wrMask[15:0]);
        secStatus_reg[31:16] <= secStatus_reg[31:16] & ~(wrData_reg[31:16] & wrMask[31:16]);
      end
      if (gotUr) begin
        statusCommand_reg[MASTER_ABORT_BIT] <= 1'b1;
        secStatus_reg[MASTER_ABORT_BIT]     <= 1'b1;
      end
      if (gotCa) begin
        statusCommand_reg[TARGET_ABORT_BIT] <= 1'b1;
        secStatus_reg[TARGET_ABORT_BIT]     <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Header log: every completion overwrites the captured words, so software
  // sees the most recent one only.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hdrWord1_reg <= 32'h0000_0000;
      hdrWord2_reg <= 32'h0000_0000;
    end else if (cplValid) begin
      hdrWord1_reg <= cplHdrWord1;
      hdrWord2_reg <= cplHdrWord2;
    end
  end

  // ==========================================================================
  // Ack timer: each field sits in its own byte lanes, so a strobed write
  // to one field cannot disturb the other whatever the link rate.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ackTimer_reg <= ACK_TIMER_RESET;
    end else if (doWrite && wrAddr_reg == ACK_TIMER_OFS) begin
      ackTimer_reg <= (ackTimer_reg & ~wrMask) | (wrData_reg & wrMask);
    end
  end

  // ==========================================================================
  // Interrupt status is cleared by a read of it; a new event wins the race.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irqStatus_reg <= 3'h0;
      irqMask_reg   <= 3'h0;
      irq           <= 1'b0;
    end else begin
      irqStatus_reg <= ((doRead && araddr == IRQ_STATUS_OFS) ? 3'h0 : irqStatus_reg)
                     | {cplValid, gotCa, gotUr};
      if (doWrite && wrAddr_reg == IRQ_MASK_OFS && wrStrb_reg[0]) begin
        irqMask_reg <= wrData_reg[2:0];
      end
      irq <= |(irqStatus_reg & irqMask_reg);
    end
  end

  // Read decode.
  always_comb begin
    rdHit_next = 1'b1;
    case (araddr)
      STATUS_COMMAND_OFS: rdValue_next = statusCommand_reg;
      SEC_STATUS_OFS:     rdValue_next = secStatus_reg;
      HDR_WORD1_OFS:      rdValue_next = hdrWord1_reg;
      HDR_WORD2_OFS:      rdValue_next = hdrWord2_reg;
      ACK_TIMER_OFS:      rdValue_next = ackTimer_reg;
      IRQ_STATUS_OFS:     rdValue_next = {29'h0, irqStatus_reg};
      IRQ_MASK_OFS:       rdValue_next = {29'h0, irqMask_reg};
      default: begin
        rdValue_next = 32'h0000_0000;
        rdHit_next   = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // AXI4-Lite read channel: one read at a time, answer one cycle after.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (doRead) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rdValue_next;
      rresp   <= rdHit_next ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  AST_UR_SETS_MASTER_ABORT: assert property (
    gotUr |=> statusCommand_reg[MASTER_ABORT_BIT] && secStatus_reg[MASTER_ABORT_BIT])
    else $error("Unsupported request did not set both master abort flags.");

  AST_CA_SETS_TARGET_ABORT: assert property (
    gotCa |=> statusCommand_reg[TARGET_ABORT_BIT] && secStatus_reg[TARGET_ABORT_BIT])
    else $error("Completer abort did not set both target abort flags.");

  AST_HEADER_CAPTURED: assert property (
    cplValid |=> hdrWord1_reg == $past(cplHdrWord1) && hdrWord2_reg == $past(cplHdrWord2))
    else $error("Completion header not captured.");

  // The status field must be readable as logged; checked on every read of word one.
  AST_STATUS_FIELD_READ: assert property (
    (doRead && araddr == HDR_WORD1_OFS)
      |=> rdata[CPL_STATUS_MSB:CPL_STATUS_LSB]
          == $past(hdrWord1_reg[CPL_STATUS_MSB:CPL_STATUS_LSB]))
    else $error("Header word one read does not show the logged completion status.");

  AST_CA_STATUS_LOGGED: assert property (
    gotCa |=> hdrWord1_reg[CPL_STATUS_MSB:CPL_STATUS_LSB] == CPL_STATUS_CA)
    else $error("Completer abort status not logged in header word one.");

  AST_UR_STATUS_LOGGED: assert property (
    gotUr |=> hdrWord1_reg[CPL_STATUS_MSB:CPL_STATUS_LSB] == CPL_STATUS_UR)
    else $error("Unsupported request status not logged in header word one.");

  AST_ACK_FIELDS_INDEPENDENT: assert property (
    (doWrite && wrAddr_reg == ACK_TIMER_OFS && wrStrb_reg == 4'h3)
      |=> ackTimer_reg[31:16] == $past(ackTimer_reg[31:16], 1))
    else $error("Round trip write disturbed the replay limit field.");

  COV_UR: cover property (gotUr ##[1:20] (doRead && araddr == STATUS_COMMAND_OFS));
  COV_CA: cover property (gotCa ##[1:20] (doRead && araddr == SEC_STATUS_OFS));
  COV_ACK: cover property (doWrite && wrAddr_reg == ACK_TIMER_OFS && wrStrb_reg == 4'hc);
  COV_IRQ: cover property ($rose(irq));

endmodule : cpl_err_log

// file: verif/cpl_completer_model.sv
/*
 * Completer model facing the root port: answers each fired request with a
 * one-cycle completion header pulse.
 * Assumes the bench fires at most one request per two cycles.
 */
`timescale 1ns/10ps
module cpl_completer_model
  import cpl_err_log_pkg::*;
(
  // Clock, reset and bench commands.
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        fire,
  input  wire logic [1:0]  kind,
  input  wire logic [31:0] seed,
  // Completion header toward the port.
  output logic             cplValid,
  output logic [31:0]      cplHdrWord1,
  output logic [31:0]      cplHdrWord2
);
  // ==========================================================================
  // Kind 0 is a refused request, kind 1 an abort, kind 2 a success.
  // Outside a pulse the words toggle, so a stale capture cannot pass.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cplValid    <= 1'b0;
      cplHdrWord1 <= 32'h0;
      cplHdrWord2 <= 32'h0;
    end else if (fire) begin
      cplValid    <= 1'b1;
      cplHdrWord1 <= {seed[31:24], ((kind == 2'h0) ? CPL_STATUS_UR :
                      (kind == 2'h1) ? CPL_STATUS_CA : 3'h0), seed[20:0]};
      cplHdrWord2 <= ~seed;
    end else begin
      cplValid    <= 1'b0;
      cplHdrWord1 <= ~cplHdrWord1;
      cplHdrWord2 <= ~cplHdrWord2;
    end
  end
endmodule : cpl_completer_model

// file: verif/tb_top.sv
/*
 * Self-checking bench of the completion error logger over AXI4-Lite.
 * Assumes the completer model and the package compile first.
 */
`timescale 1ns/10ps
module tb_top;
  import cpl_err_log_pkg::*;
  logic core_clk = 0, srst = 1, fire = 0, irq;
  logic [1:0] kind = 0;
  logic [31:0] seed = 0, cplHdrWord1, cplHdrWord2, wdata = 0, rdata;
  logic cplValid, awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
  logic arvalid = 0, arready, rvalid, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp;
  logic [33:0] expQ[$];
  int fail_count = 0, total_checks = 0;
  cpl_completer_model cpl_completer_model_i (.core_clk(core_clk), .srst(srst), .fire(fire),
    .kind(kind), .seed(seed), .cplValid(cplValid), .cplHdrWord1(cplHdrWord1),
    .cplHdrWord2(cplHdrWord2));
  cpl_err_log cpl_err_log_i (.core_clk(core_clk), .srst(srst), .cplValid(cplValid),
    .cplHdrWord1(cplHdrWord1), .cplHdrWord2(cplHdrWord2), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq));
  // ==========================================================================
  // Clock and comparison helpers.
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    total_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("mismatches %0d of %0d checks", fail_count, total_checks);
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // Write with both channels offered together; bready held until bvalid.
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] expResp);
    @(posedge core_clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    check({32'h0, bresp}, {32'h0, expResp});
  endtask : axiWrite
  // Read; the expected answer is queued for the monitor.
  task automatic axiRead(input logic [7:0] a, input logic [33:0] want);
    @(posedge core_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    expQ.push_back(want);
    forever begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
  endtask : axiRead
  // Monitor: every read handshake consumes the oldest expectation.
  always @(posedge core_clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) check({rresp, rdata}, expQ.pop_front());
  end
  // Watchdog sized well past the whole sequence.
  initial begin
    repeat (4000) @(posedge core_clk);
    fail_count++;
    tally_and_finish();
  end
  // ==========================================================================
  // Main sequence.
  initial begin
    logic [31:0] w1, flag, v;
    logic [2:0] mask, st;
    void'($urandom(32'h9e8fb885));
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    // Reset values and an unmapped address.
    for (int i = 0; i < 7; i++) axiRead(8'(i * 4), 34'h0);
    axiRead(8'h1c, {RESP_SLVERR, 32'h0});
    axiWrite(8'h1c, 32'h1, 4'hf, RESP_SLVERR);
    // Refused, aborted and successful completions under varied masks.
    for (int k = 0; k < 3; k++) begin
      mask = (k == 0) ? 3'h7 : (k == 1) ? 3'h2 : 3'h3;
      axiWrite(IRQ_MASK_OFS, {29'h0, mask}, 4'hf, RESP_OKAY);
      seed = $urandom;
      st = (k == 0) ? 3'h1 : (k == 1) ? 3'h4 : 3'h0;
      w1 = {seed[31:24], st, seed[20:0]};
      flag = (k == 0) ? 32'h2000_0000 : (k == 1) ? 32'h1000_0000 : 32'h0;
      v = {29'h0, 1'b1, k == 1, k == 0};
      @(posedge core_clk);
      fire <= 1'b1;
      kind <= 2'(k);
      @(posedge core_clk);
      fire <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1 check({33'h0, irq}, {33'h0, |(v[2:0] & mask)});
      axiRead(STATUS_COMMAND_OFS, {2'h0, flag});
      axiRead(SEC_STATUS_OFS, {2'h0, flag});
      axiRead(HDR_WORD1_OFS, {2'h0, w1});
      axiRead(HDR_WORD2_OFS, {2'h0, ~seed});
      axiRead(IRQ_STATUS_OFS, {2'h0, v});
      axiRead(IRQ_STATUS_OFS, 34'h0);
      #1 check({33'h0, irq}, 34'h0);
      axiWrite(STATUS_COMMAND_OFS, flag, 4'hf, RESP_OKAY);
      axiWrite(SEC_STATUS_OFS, flag, 4'hf, RESP_OKAY);
      axiRead(STATUS_COMMAND_OFS, 34'h0);
      axiRead(SEC_STATUS_OFS, 34'h0);
    end
    // Each ack timer field written alone leaves the other intact. The bench
    // stands for a link held at the first rate, the only one at which
    // software may touch these fields.
    w1 = $urandom;
    axiWrite(ACK_TIMER_OFS, w1, 4'hf, RESP_OKAY);
    v = $urandom;
    axiWrite(ACK_TIMER_OFS, v, 4'h3, RESP_OKAY);
    axiRead(ACK_TIMER_OFS, {2'h0, w1[31:16], v[15:0]});
    w1 = $urandom;
    axiWrite(ACK_TIMER_OFS, w1, 4'hc, RESP_OKAY);
    axiRead(ACK_TIMER_OFS, {2'h0, w1[31:16], v[15:0]});
    repeat (3) @(posedge core_clk);
    tally_and_finish();
  end
endmodule : tb_top
